// >>> hw/afe_ctrl_pkg.sv
package afe_ctrl_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_INPUT_CFG     = 8'h10;
    localparam logic [7:0] ADDR_GAIN_RED      = 8'h12;
    localparam logic [7:0] ADDR_GAIN_GREEN    = 8'h14;
    localparam logic [7:0] ADDR_GAIN_BLUE     = 8'h16;
    localparam logic [7:0] ADDR_RED_OFS_HI    = 8'h18;
    localparam logic [7:0] ADDR_RED_OFS_LO    = 8'h19;
    localparam logic [7:0] ADDR_GREEN_OFS_HI  = 8'h1A;
    localparam logic [7:0] ADDR_GREEN_OFS_LO  = 8'h1B;
    localparam logic [7:0] ADDR_BLUE_OFS_HI   = 8'h1C;
    localparam logic [7:0] ADDR_BLUE_OFS_LO   = 8'h1D;
    localparam logic [7:0] ADDR_CLAMP_START_H = 8'h24;
    localparam logic [7:0] ADDR_CLAMP_START_L = 8'h25;
    localparam logic [7:0] ADDR_CLAMP_WIDTH   = 8'h26;
    localparam logic [7:0] ADDR_BLACK_CFG     = 8'h27;
    localparam logic [7:0] ADDR_SLICER_A      = 8'h30;
    localparam logic [7:0] ADDR_SLICER_B      = 8'h31;
    localparam logic [7:0] ADDR_HPER_H        = 8'h40;
    localparam logic [7:0] ADDR_HPER_L        = 8'h41;
    localparam logic [7:0] ADDR_HPW_H         = 8'h42;
    localparam logic [7:0] ADDR_HPW_L         = 8'h43;
    localparam logic [7:0] ADDR_VPER_H        = 8'h44;
    localparam logic [7:0] ADDR_VPER_L        = 8'h45;
    localparam logic [7:0] ADDR_VPW           = 8'h46;
    localparam logic [7:0] ADDR_VPW_L         = 8'h47;
    localparam logic [7:0] ADDR_MEAS_CFG      = 8'h4F;
    localparam logic [7:0] ADDR_LOOP_CFG      = 8'h60;
    localparam logic [7:0] ADDR_PHASE_GAIN    = 8'h74;
    localparam logic [7:0] ADDR_SYNC_OUT_CFG  = 8'h7A;

    // Field positions
    localparam int BIT_DC_COUPLE     = 3;
    localparam int BIT_EXT_CLAMP_LO  = 6;
    localparam int BIT_EXT_CLAMP_HI  = 7;
    localparam int BIT_BLACK_OFF     = 0;
    localparam int BIT_HALF_RANGE    = 1;
    localparam int BIT_COAST_CLAMP   = 2;
    localparam int BIT_VUNIT_XTAL    = 0;
    localparam int BIT_HS_MASK_OFF   = 4;

    // Reset values
    localparam logic [7:0] RST_INPUT_CFG   = 8'h00;
    localparam logic [7:0] RST_GAIN        = 8'h55;
    localparam logic [7:0] RST_OFS_HI      = 8'h80;
    localparam logic [7:0] RST_OFS_LO      = 8'h00;
    localparam logic [7:0] RST_START_H     = 8'h00;
    localparam logic [7:0] RST_START_L     = 8'h08;
    localparam logic [7:0] RST_WIDTH       = 8'h10;
    localparam logic [7:0] RST_BYTE_ZERO   = 8'h00;
    localparam logic [7:0] RST_PHASE_GAIN  = 8'h49;

    // Timing
    localparam int CLK_PERIOD_PS       = 4000;
    localparam int GAIN_TIMEOUT_MS     = 100;
    localparam int GAIN_TIMEOUT_CYC    =
        GAIN_TIMEOUT_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int VUNIT_XTAL_DIV      = 512;
    localparam int HAVG_COUNT          = 16;

    // Gain and offset words driven to the analog side
    typedef struct packed {
        logic [9:0] red;
        logic [9:0] green;
        logic [9:0] blue;
    } rgb10_t;

    // Sync timing results
    typedef struct packed {
        logic [15:0] h_period;
        logic [15:0] h_width;
        logic [11:0] v_period;
        logic [11:0] v_width;
    } meas_t;

endpackage

// >>> hw/afe_ctrl.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module afe_ctrl
    import afe_ctrl_pkg::*;
#(
    parameter int GAIN_TIMEOUT = GAIN_TIMEOUT_CYC,
    parameter int START_W      = 16
) (
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    // Register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    // Sync and pixel inputs
    input  wire logic        HSYNC_IN,
    input  wire logic        VSYNC_IN,
    input  wire logic        GREEN_SYNC_IN,
    input  wire logic        PIXEL_TICK,
    input  wire logic        LOOP_COAST,
    input  wire logic        PROTECT_DETECT,
    input  wire logic        PROTECT_MASK,
    input  wire logic        EXT_CLAMP_IN,
    // Analog-side controls
    output logic             CLAMP,
    output logic             DC_COUPLE,
    output logic             HSYNC_OUT,
    output logic             LOOP_SYNC,
    output logic      [3:0]  SLICE_THRESH,
    output logic      [7:0]  SLICE_CFG,
    output logic      [7:0]  PHASE_GAIN,
    output rgb10_t           AMP_GAIN,
    output rgb10_t           OFFSET_CONV,
    output rgb10_t           DIGITAL_OFFSET,
    output logic             OFFSET_HALF,
    output logic             BLACK_COMP_ON
);

    initial begin
        if (START_W < 8 || START_W > 16)
            $error("START_W must be 8 to 16");
        if (GAIN_TIMEOUT < 1)
            $error("GAIN_TIMEOUT must be positive");
    end

    // Register storage
    logic [7:0] input_cfg, black_cfg, meas_cfg, loop_cfg, out_cfg;
    logic [7:0] start_h, start_l, clamp_width, slice_a, slice_b;
    logic [7:0] phase_gain_control;
    logic [7:0] gain_reg [3];
    logic [7:0] ofs_hi   [3];
    logic [7:0] ofs_lo   [3];
    meas_t      meas;

    // Writes from software
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            input_cfg          <= RST_INPUT_CFG;
            black_cfg          <= RST_BYTE_ZERO;
            meas_cfg           <= RST_BYTE_ZERO;
            loop_cfg           <= RST_BYTE_ZERO;
            out_cfg            <= RST_BYTE_ZERO;
            start_h            <= RST_START_H;
            start_l            <= RST_START_L;
            clamp_width        <= RST_WIDTH;
            slice_a            <= RST_BYTE_ZERO;
            slice_b            <= RST_BYTE_ZERO;
            phase_gain_control <= RST_PHASE_GAIN;
            for (int i = 0; i < 3; i++) begin
                gain_reg[i] <= RST_GAIN;
                ofs_hi[i]   <= RST_OFS_HI;
                ofs_lo[i]   <= RST_OFS_LO;
            end
        end else if (WR) begin
            unique case (ADDR)
                ADDR_INPUT_CFG:     input_cfg          <= WDATA;
                ADDR_BLACK_CFG:     black_cfg          <= WDATA;
                ADDR_MEAS_CFG:      meas_cfg           <= WDATA;
                ADDR_LOOP_CFG:      loop_cfg           <= WDATA;
                ADDR_SYNC_OUT_CFG:  out_cfg            <= WDATA;
                ADDR_CLAMP_START_H: start_h            <= WDATA;
                ADDR_CLAMP_START_L: start_l            <= WDATA;
                ADDR_CLAMP_WIDTH:   clamp_width        <= WDATA;
                ADDR_SLICER_A:      slice_a            <= WDATA;
                ADDR_SLICER_B:      slice_b            <= WDATA;
                ADDR_PHASE_GAIN:    phase_gain_control <= WDATA;
                ADDR_GAIN_RED:      gain_reg[0]        <= WDATA;
                ADDR_GAIN_GREEN:    gain_reg[1]        <= WDATA;
                ADDR_GAIN_BLUE:     gain_reg[2]        <= WDATA;
                ADDR_RED_OFS_HI:    ofs_hi[0]          <= WDATA;
                ADDR_RED_OFS_LO:    ofs_lo[0]          <= WDATA;
                ADDR_GREEN_OFS_HI:  ofs_hi[1]          <= WDATA;
                ADDR_GREEN_OFS_LO:  ofs_lo[1]          <= WDATA;
                ADDR_BLUE_OFS_HI:   ofs_hi[2]          <= WDATA;
                ADDR_BLUE_OFS_LO:   ofs_lo[2]          <= WDATA;
                default: ;
            endcase
        end
    end

    // Read data, one cycle after the strobe; results are read-only
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            unique case (ADDR)
                ADDR_INPUT_CFG:     RDATA <= input_cfg;
                ADDR_BLACK_CFG:     RDATA <= black_cfg;
                ADDR_MEAS_CFG:      RDATA <= meas_cfg;
                ADDR_LOOP_CFG:      RDATA <= loop_cfg;
                ADDR_SYNC_OUT_CFG:  RDATA <= out_cfg;
                ADDR_CLAMP_START_H: RDATA <= start_h;
                ADDR_CLAMP_START_L: RDATA <= start_l;
                ADDR_CLAMP_WIDTH:   RDATA <= clamp_width;
                ADDR_SLICER_A:      RDATA <= slice_a;
                ADDR_SLICER_B:      RDATA <= slice_b;
                ADDR_PHASE_GAIN:    RDATA <= phase_gain_control;
                ADDR_GAIN_RED:      RDATA <= gain_reg[0];
                ADDR_GAIN_GREEN:    RDATA <= gain_reg[1];
                ADDR_GAIN_BLUE:     RDATA <= gain_reg[2];
                ADDR_RED_OFS_HI:    RDATA <= ofs_hi[0];
                ADDR_RED_OFS_LO:    RDATA <= ofs_lo[0];
                ADDR_GREEN_OFS_HI:  RDATA <= ofs_hi[1];
                ADDR_GREEN_OFS_LO:  RDATA <= ofs_lo[1];
                ADDR_BLUE_OFS_HI:   RDATA <= ofs_hi[2];
                ADDR_BLUE_OFS_LO:   RDATA <= ofs_lo[2];
                ADDR_HPER_H:        RDATA <= meas.h_period[15:8];
                ADDR_HPER_L:        RDATA <= meas.h_period[7:0];
                ADDR_HPW_H:         RDATA <= meas.h_width[15:8];
                ADDR_HPW_L:         RDATA <= meas.h_width[7:0];
                ADDR_VPER_H:        RDATA <= {4'h0, meas.v_period[11:8]};
                ADDR_VPER_L:        RDATA <= meas.v_period[7:0];
                ADDR_VPW:           RDATA <= {4'h0, meas.v_width[11:8]};
                ADDR_VPW_L:         RDATA <= meas.v_width[7:0];
                default:            RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    // Two-flop synchronisers for pin inputs
    logic [7:0] sync1, sync2;
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end else begin
            sync1 <= {HSYNC_IN, VSYNC_IN, GREEN_SYNC_IN, PIXEL_TICK,
                      LOOP_COAST, PROTECT_DETECT, PROTECT_MASK,
                      EXT_CLAMP_IN};
            sync2 <= sync1;
        end
    end

    logic hs, vs, gs, pix, coast, prot_det, prot_mask, ext_clamp;
    assign {hs, vs, gs, pix, coast, prot_det, prot_mask, ext_clamp} = sync2;

    // Edge detection on synchronised sync
    logic hs_d, vs_d, ext_d;
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            hs_d  <= 1'b0;
            vs_d  <= 1'b0;
            ext_d <= 1'b0;
        end else begin
            hs_d  <= hs;
            vs_d  <= vs;
            ext_d <= ext_clamp;
        end
    end
    logic hs_rise, hs_fall, vs_rise, vs_fall, ext_rise;
    assign hs_rise  = hs & ~hs_d;
    assign hs_fall  = ~hs & hs_d;
    assign vs_rise  = vs & ~vs_d;
    assign vs_fall  = ~vs & vs_d;
    assign ext_rise = ext_clamp & ~ext_d;

    // Copy-protection mask on green composite sync and sync output
    logic mask_active;
    assign mask_active = prot_det & ~prot_mask;
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            LOOP_SYNC <= 1'b0;
            HSYNC_OUT <= 1'b0;
        end else begin
            LOOP_SYNC <= gs & (~prot_det | prot_mask);
            HSYNC_OUT <= out_cfg[BIT_HS_MASK_OFF] ? hs
                         : (hs & ~mask_active);
        end
    end

    // Clamp placement counted in pixels from trailing sync edge
    logic [START_W-1:0] start_pos;
    logic [15:0]        start_full;
    logic [START_W-1:0] pix_cnt;
    logic [START_W-1:0] next_pix;
    logic [7:0]         width_cnt;
    logic               counting;
    logic               clamp_on;
    logic               clamp_allow;
    assign start_full  = {start_h, start_l};
    assign start_pos   = start_full[START_W-1:0];
    assign next_pix    = pix_cnt + START_W'(1);
    assign clamp_allow = ~coast | loop_cfg[BIT_COAST_CLAMP];

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            pix_cnt   <= '0;
            width_cnt <= 8'h00;
            counting  <= 1'b0;
            clamp_on  <= 1'b0;
        end else if (hs_fall) begin
            pix_cnt   <= '0;
            width_cnt <= clamp_width;
            counting  <= (start_pos != '0);
            clamp_on  <= (start_pos == '0) && (clamp_width != 8'h00);
        end else if (pix) begin
            if (counting) begin
                pix_cnt <= next_pix;
                if (next_pix == start_pos) begin
                    counting <= 1'b0;
                    clamp_on <= (clamp_width != 8'h00);
                end
            end else if (clamp_on) begin
                if (width_cnt == 8'h01)
                    clamp_on <= 1'b0;
                width_cnt <= width_cnt - 8'h01;
            end
        end
    end

    // Clamp output only in AC mode, and while coasting only when loop_cfg enables coast clamping
    logic dc_mode;
    assign dc_mode = input_cfg[BIT_DC_COUPLE];
    assign CLAMP     = clamp_on & ~dc_mode & clamp_allow;
    assign DC_COUPLE = dc_mode;

    // Gain transfer: clamp pulse, external clamp, or timeout
    logic        clamp_d;
    logic        gain_pending;
    logic [31:0] gain_timer;
    logic        ext_sel;
    logic        gain_load;
    assign ext_sel = |input_cfg[BIT_EXT_CLAMP_HI:BIT_EXT_CLAMP_LO];
    always_ff @(posedge REF_CLK) begin
        if (RST)
            clamp_d <= 1'b0;
        else
            clamp_d <= CLAMP;
    end
    assign gain_load = ext_sel ? ext_rise : (CLAMP & ~clamp_d);

    logic gain_write;
    assign gain_write = WR && (ADDR == ADDR_GAIN_RED ||
                               ADDR == ADDR_GAIN_GREEN ||
                               ADDR == ADDR_GAIN_BLUE);
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            gain_pending <= 1'b0;
            gain_timer   <= 32'h0;
            AMP_GAIN     <= {3{2'b00, RST_GAIN}};
        end else begin
            if (gain_load || gain_timer == 32'(GAIN_TIMEOUT - 1)) begin
                AMP_GAIN <= {2'b00, gain_reg[0], 2'b00, gain_reg[1],
                             2'b00, gain_reg[2]};
                gain_timer <= 32'h0;
            end else if (gain_pending) begin
                gain_timer <= gain_timer + 32'h1;
            end
            // A new write in the load cycle stays pending
            gain_pending <= gain_write |
                (gain_pending & ~gain_load &
                 (gain_timer != 32'(GAIN_TIMEOUT - 1)));
        end
    end

    // Offset routing by black level compensation mode
    logic comp_on;
    assign comp_on = ~black_cfg[BIT_BLACK_OFF];
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            OFFSET_CONV    <= '0;
            DIGITAL_OFFSET <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (comp_on) begin
                    DIGITAL_OFFSET[30-10*i-1 -: 10] <=
                        {ofs_hi[i], ofs_lo[i][7:6]};
                end else begin
                    OFFSET_CONV[30-10*i-1 -: 10] <=
                        {ofs_hi[i], ofs_lo[i][7:6]};
                end
            end
        end
    end
    assign OFFSET_HALF   = black_cfg[BIT_HALF_RANGE];
    assign BLACK_COMP_ON = comp_on;
    assign SLICE_THRESH  = slice_a[3:0];
    assign SLICE_CFG     = slice_b;
    assign PHASE_GAIN    = phase_gain_control;

    // Horizontal measurement over sixteen periods and pulses
    logic [15:0] hp_acc, hw_acc;
    logic [3:0]  hp_n, hw_n;
    logic        h_seen;
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            hp_acc        <= 16'h0;
            hw_acc        <= 16'h0;
            hp_n          <= 4'h0;
            hw_n          <= 4'h0;
            h_seen        <= 1'b0;
            meas.h_period <= 16'h0;
            meas.h_width  <= 16'h0;
        end else begin
            if (hs_rise) begin
                h_seen <= 1'b1;
                if (h_seen) begin
                    hp_n <= hp_n + 4'h1;
                    if (hp_n == 4'(HAVG_COUNT - 1)) begin
                        meas.h_period <= hp_acc + 16'h1;
                        hp_acc        <= 16'h0;
                    end else begin
                        hp_acc <= hp_acc + 16'h1;
                    end
                end
            end else if (h_seen) begin
                hp_acc <= hp_acc + 16'h1;
            end
            if (hs) begin
                hw_acc <= hw_acc + 16'h1;
            end else if (hs_fall) begin
                hw_n <= hw_n + 4'h1;
                if (hw_n == 4'(HAVG_COUNT - 1)) begin
                    meas.h_width <= hw_acc;
                    hw_acc       <= 16'h0;
                end
            end
        end
    end

    // Vertical measurement in lines or 512-clock units
    logic [8:0]  xdiv;
    logic        vunit;
    logic [11:0] vp_acc, vw_acc;
    assign vunit = meas_cfg[BIT_VUNIT_XTAL]
                   ? (xdiv == 9'(VUNIT_XTAL_DIV - 1)) : hs_rise;
    always_ff @(posedge REF_CLK) begin
        if (RST)
            xdiv <= 9'h0;
        else
            xdiv <= xdiv + 9'h1;
    end
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            vp_acc        <= 12'h0;
            vw_acc        <= 12'h0;
            meas.v_period <= 12'h0;
            meas.v_width  <= 12'h0;
        end else begin
            if (vs_rise) begin
                meas.v_period <= vp_acc;
                vp_acc        <= {11'h000, vunit};  // Edge unit opens frame
                vw_acc        <= {11'h000, vunit};
            end else if (vunit) begin
                vp_acc <= vp_acc + 12'h1;
                if (vs)
                    vw_acc <= vw_acc + 12'h1;
            end
            if (vs_fall)
                meas.v_width <= vw_acc;
        end
    end

endmodule

// >>> bench/afe_ctrl_chk.sv
`timescale 1ns/1ps
module afe_ctrl_chk
    import afe_ctrl_pkg::*;
#(
    parameter int GAIN_TIMEOUT = 50
) (
    // Clock, reset and register writes
    input wire logic       REF_CLK,
    input wire logic       RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    // Source conditions and block outputs
    input wire logic       LOOP_COAST,
    input wire logic       PROTECT_DETECT,
    input wire logic       CLAMP,
    input wire logic       DC_COUPLE,
    input wire logic       HSYNC_OUT,
    input wire logic       LOOP_SYNC,
    input wire logic [3:0] SLICE_THRESH,
    input wire logic [7:0] PHASE_GAIN,
    input wire rgb10_t     AMP_GAIN,
    input wire logic       OFFSET_HALF,
    input wire logic       BLACK_COMP_ON
);
    localparam int GAIN_WAIT = GAIN_TIMEOUT + 14;
    logic       coast_ok;
    logic       hs_unmask;
    logic [7:0] gain_w;

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);

    // Shadow of written bits that no output shows
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            coast_ok  <= 1'b0;
            hs_unmask <= 1'b0;
        end else if (WR && ADDR == ADDR_LOOP_CFG) begin
            coast_ok  <= WDATA[BIT_COAST_CLAMP];
        end else if (WR && ADDR == ADDR_SYNC_OUT_CFG) begin
            hs_unmask <= WDATA[BIT_HS_MASK_OFF];
        end
    end
    // Last red gain written
    always_ff @(posedge REF_CLK) begin
        if (WR && ADDR == ADDR_GAIN_RED) begin
            gain_w <= WDATA;
        end
    end

    a_couple_bit: assert property (WR && ADDR == ADDR_INPUT_CFG |=>
        DC_COUPLE == $past(WDATA[BIT_DC_COUPLE])) else $error("coupling");
    a_dc_no_clamp: assert property (DC_COUPLE |-> !CLAMP)
        else $error("clamp in dc mode");
    a_coast_gate: assert property ((LOOP_COAST && !coast_ok)[*4]
        |-> !CLAMP) else $error("clamp while coasting");
    a_slice_code: assert property (WR && ADDR == ADDR_SLICER_A |=>
        SLICE_THRESH == $past(WDATA[3:0])) else $error("slicer code");
    a_phase_gain: assert property (WR && ADDR == ADDR_PHASE_GAIN |=>
        PHASE_GAIN == $past(WDATA)) else $error("phase gain");
    a_black_bits: assert property (WR && ADDR == ADDR_BLACK_CFG |=>
        OFFSET_HALF == $past(WDATA[BIT_HALF_RANGE])
        && BLACK_COMP_ON != $past(WDATA[BIT_BLACK_OFF]))
        else $error("black level bits");
    a_loop_mask: assert property (PROTECT_DETECT[*4] |-> !LOOP_SYNC)
        else $error("loop sync not masked");
    a_hs_mask: assert property ((PROTECT_DETECT && !hs_unmask)[*4]
        |-> !HSYNC_OUT) else $error("sync output not masked");
    a_gain_apply: assert property (WR && ADDR == ADDR_GAIN_RED |=>
        ##[0:GAIN_WAIT] AMP_GAIN.red == {2'b00, gain_w})
        else $error("gain not applied");
endmodule

// >>> bench/video_src.sv
`timescale 1ns/1ps
module video_src #(
    parameter int LINE_PIX = 64,
    parameter int HS_PIX   = 6,
    parameter int VS_LINES = 2,
    parameter int FR_LINES = 8
) (
    // Control
    input  wire logic clk,
    input  wire logic run,
    // Sync lines and pixel pacing
    output logic      hsync,
    output logic      vsync,
    output logic      green_sync,
    output logic      pix_tick
);
    int div;
    int pix;
    int line;

    // Raster position, four clocks per pixel
    always_ff @(posedge clk) begin
        if (!run) begin
            div  <= 0;
            pix  <= 0;
            line <= 0;
        end else begin
            div <= (div + 1) % 4;
            if (div == 3) begin
                pix <= (pix + 1) % LINE_PIX;
            end
            if (div == 3 && pix == LINE_PIX - 1) begin
                line <= (line + 1) % FR_LINES;
            end
        end
    end
    // Syncs idle low when stopped; tick kept away from sync edges
    assign hsync      = run && pix < HS_PIX;
    assign vsync      = run && line < VS_LINES;
    assign green_sync = hsync;
    assign pix_tick   = run && div == 2;
endmodule

// >>> bench/afe_ctrl_tb_top.sv
`timescale 1ns/1ps
module afe_ctrl_tb_top;
    import afe_ctrl_pkg::*;
    localparam int GT   = 50;
    localparam int LINE = 256;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] q;
    } row_t;
    logic       REF_CLK, RST, WR, RD, run, hs_d, clamp_d;
    logic       HSYNC_IN, VSYNC_IN, GREEN_SYNC_IN, PIXEL_TICK;
    logic       LOOP_COAST, PROTECT_DETECT, CLAMP, DC_COUPLE, HSYNC_OUT;
    logic       OFFSET_HALF, BLACK_COMP_ON, LOOP_SYNC;
    logic [3:0] SLICE_THRESH;
    logic [7:0] ADDR, WDATA, RDATA, SLICE_CFG, PHASE_GAIN;
    rgb10_t     AMP_GAIN, OFFSET_CONV, DIGITAL_OFFSET;
    int         ticks, start_seen, wid_seen, rises, hs_hi, r0, ls_hi, l0;
    int         err_count, compares;
    row_t       rows [8] = '{
        '{8'h18, 8'hA5, 8'hA5}, '{8'h1D, 8'h40, 8'h40},
        '{8'h74, 8'h4C, 8'h4C}, '{8'h30, 8'h0B, 8'h0B},
        '{8'h31, 8'h5A, 8'h5A}, '{8'h26, 8'h03, 8'h03},
        '{8'h25, 8'h04, 8'h04}, '{8'h05, 8'h77, 8'h00}};

    afe_ctrl #(.GAIN_TIMEOUT(GT)) uut (
        .REF_CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .HSYNC_IN,
        .VSYNC_IN, .GREEN_SYNC_IN, .PIXEL_TICK, .LOOP_COAST,
        .PROTECT_DETECT, .PROTECT_MASK(1'b0), .EXT_CLAMP_IN(1'b0),
        .CLAMP, .DC_COUPLE, .HSYNC_OUT, .LOOP_SYNC, .SLICE_THRESH,
        .SLICE_CFG, .PHASE_GAIN, .AMP_GAIN, .OFFSET_CONV, .DIGITAL_OFFSET,
        .OFFSET_HALF, .BLACK_COMP_ON);
    video_src src (.clk(REF_CLK), .run, .hsync(HSYNC_IN),
        .vsync(VSYNC_IN), .green_sync(GREEN_SYNC_IN), .pix_tick(PIXEL_TICK));

    // Clock source
    initial begin
        REF_CLK = 1'b0;
        forever #2 REF_CLK = ~REF_CLK;
    end
    // Clamp placement and sync output bookkeeping at the pins
    always @(posedge REF_CLK) begin
        if (CLAMP && !clamp_d) begin
            start_seen = ticks;
            wid_seen   = 0;
            rises++;
        end
        if (PIXEL_TICK && CLAMP) wid_seen++;
        if (PIXEL_TICK) ticks++;
        if (hs_d && !HSYNC_IN) ticks = 0;
        if (HSYNC_OUT) hs_hi++;
        if (LOOP_SYNC) ls_hi++;
        hs_d    <= HSYNC_IN;
        clamp_d <= CLAMP;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %0h, want %0h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge REF_CLK);
        WR    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge REF_CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge REF_CLK);
        RD   <= 1'b0;
        #1;
        chk(32'(RDATA), 32'(exp));
    endtask
    task automatic wrap_up;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        RST = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 8'h00;
        WDATA = 8'h00;
        run = 1'b0;
        LOOP_COAST = 1'b0;
        PROTECT_DETECT = 1'b0;
        cyc(16);
        RST <= 1'b0;
        #1;
        chk(32'(AMP_GAIN), {2'b00, {3{10'h055}}});
        rd(ADDR_PHASE_GAIN, 8'h49);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].q);
        end
        chk(32'(SLICE_THRESH), 32'h0B);
        chk(32'(SLICE_CFG), 32'h5A);
        wr(ADDR_BLACK_CFG, 8'h03);
        cyc(1);
        #1;
        chk(32'(OFFSET_CONV), {2'b00, 10'h294, 10'h200, 10'h201});
        chk(32'({OFFSET_HALF, BLACK_COMP_ON}), 32'h2);
        wr(ADDR_BLACK_CFG, 8'h00);
        cyc(1);
        #1;
        chk(32'(DIGITAL_OFFSET), {2'b00, 10'h294, 10'h200, 10'h201});
        run <= 1'b1;
        cyc(3 * LINE);
        chk(start_seen, 4);
        chk(wid_seen, 3);
        r0 = rises;
        l0 = ls_hi;
        cyc(4 * LINE);
        chk(rises - r0, 4);
        chk(ls_hi - l0, 96);
        LOOP_COAST <= 1'b1;
        r0 = rises;
        cyc(2 * LINE);
        chk(rises - r0, 0);
        wr(ADDR_LOOP_CFG, 8'h04);
        r0 = rises;
        cyc(2 * LINE);
        chk(rises - r0, 2);
        LOOP_COAST <= 1'b0;
        wr(ADDR_INPUT_CFG, 8'h08);
        r0 = rises;
        cyc(2 * LINE);
        chk(rises - r0, 0);
        chk(32'(DC_COUPLE), 32'h1);
        wr(ADDR_INPUT_CFG, 8'h00);
        PROTECT_DETECT <= 1'b1;
        cyc(8);
        r0 = hs_hi;
        l0 = ls_hi;
        cyc(LINE);
        chk(hs_hi - r0, 0);
        chk(ls_hi - l0, 0);
        wr(ADDR_SYNC_OUT_CFG, 8'h10);
        cyc(8);
        r0 = hs_hi;
        cyc(LINE);
        chk(hs_hi - r0, 24);
        PROTECT_DETECT <= 1'b0;
        wr(ADDR_GAIN_RED, 8'h60);
        cyc(LINE);
        #1;
        chk(32'(AMP_GAIN.red), 32'h060);
        run <= 1'b0;
        wr(ADDR_GAIN_GREEN, 8'h2A);
        cyc(GT + 10);
        #1;
        chk(32'(AMP_GAIN.green), 32'h02A);
        run <= 1'b1;
        cyc(32 * LINE);
        rd(ADDR_HPER_H, 8'h10);
        rd(ADDR_HPER_L, 8'h00);
        rd(ADDR_HPW_H, 8'h01);
        rd(ADDR_HPW_L, 8'h80);
        rd(ADDR_VPER_L, 8'h08);
        rd(ADDR_VPW_L, 8'h02);
        wr(ADDR_HPER_H, 8'hFF);
        rd(ADDR_HPER_H, 8'h10);
        wr(ADDR_MEAS_CFG, 8'h01);
        cyc(24 * LINE);
        rd(ADDR_VPER_L, 8'h04);
        rd(ADDR_VPW_L, 8'h01);
        wr(ADDR_CLAMP_START_L, 8'h31);
        cyc(2 * LINE);
        chk(start_seen, 49);
        RST <= 1'b1;
        cyc(2);
        RST <= 1'b0;
        #1;
        chk(32'(PHASE_GAIN), 32'h49);
        wrap_up;
    end
    // Watchdog against a hung run
    initial begin
        #200000;
        err_count++;
        wrap_up;
    end
endmodule

bind afe_ctrl afe_ctrl_chk #(.GAIN_TIMEOUT(GAIN_TIMEOUT)) mon (
    .REF_CLK, .RST, .ADDR, .WDATA, .WR, .LOOP_COAST, .PROTECT_DETECT,
    .CLAMP, .DC_COUPLE, .HSYNC_OUT, .LOOP_SYNC, .SLICE_THRESH,
    .PHASE_GAIN, .AMP_GAIN, .OFFSET_HALF, .BLACK_COMP_ON);
